// >>> lfm_pkg.sv
package lfm_pkg;
   localparam int unsigned ADDR_W = 48;
   localparam int unsigned LINE_OFF_W = 6;
   localparam int unsigned LINE_W = ADDR_W - LINE_OFF_W;
   localparam int unsigned LINE_BYTES = 64;
   localparam int unsigned DATA_W = LINE_BYTES * 8;
   localparam int unsigned SET_SPAN_BYTES = 32768;
   localparam int unsigned SET_W = 15 - LINE_OFF_W;
   localparam int unsigned SETS = 512;
   localparam int unsigned MISS_ENTRIES = 8;
   localparam int unsigned MISS_IDX_W = 3;
   localparam int unsigned STREAM_PRESET = 3;
   localparam int unsigned L1_SIZE_KB = 64;
   localparam int unsigned L2_SIZE_KB = 512;
   localparam logic [2:0] MT_UC = 3'h0;
   localparam logic [2:0] MT_WC = 3'h1;
   localparam logic [2:0] MT_WB = 3'h6;

   typedef enum logic [2:0] {
      LFM_OP_LOAD = 3'b000,
      LFM_OP_STORE = 3'b001,
      LFM_OP_FA_PLAIN = 3'b010,
      LFM_OP_FA_HINT = 3'b011,
      LFM_OP_FA_WRITE = 3'b100,
      LFM_OP_FA_NT = 3'b101,
      LFM_OP_STREAM_ST = 3'b110,
      LFM_OP_FENCE = 3'b111
   } lfm_op_e;

   typedef enum logic [1:0] {
      LFM_ST_INVALID = 2'b00,
      LFM_ST_SHARED = 2'b01,
      LFM_ST_EXCL = 2'b10,
      LFM_ST_MODIFIED = 2'b11
   } lfm_coh_e;

   typedef struct packed {
      logic valid;
      lfm_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [1:0] hint;
      logic [2:0] range_mt;
      logic [2:0] page_mt;
      logic [DATA_W-1:0] data;
   } lfm_req_s;

   typedef struct packed {
      logic valid;
      logic [LINE_W-1:0] line;
      logic nt;
      logic write_intent;
      logic hw_stream;
   } lfm_miss_s;

   typedef struct packed {
      logic valid;
      logic [MISS_IDX_W-1:0] idx;
      logic in_l2;
   } lfm_fill_s;

   typedef struct packed {
      logic valid;
      logic [LINE_W-1:0] line;
      lfm_coh_e coh;
      logic no_wb;
   } lfm_evict_s;
endpackage

// >>> lfm_wc_buf.sv
`timescale 1ns/10ps
`default_nettype none
// one-line write-combining buffer, drained as a whole line write
module lfm_wc_buf (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wr_valid,
   input wire logic [lfm_pkg::LINE_W-1:0] wr_line,
   input wire logic [lfm_pkg::DATA_W-1:0] wr_data,
   input wire logic flush,
   input wire logic drain_ready,
   output logic busy,
   output logic drain_valid,
   output logic [lfm_pkg::LINE_W-1:0] drain_line,
   output logic [lfm_pkg::DATA_W-1:0] drain_data
);
   typedef struct packed {
      logic held;
      logic out;
      logic [lfm_pkg::LINE_W-1:0] line;
      logic [lfm_pkg::DATA_W-1:0] data;
   } lfm_wc_s;
   lfm_wc_s st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (st_q.out && drain_ready) begin
         st_d.out = 1'b0;
         st_d.held = 1'b0;
      end
      if (wr_valid && !st_q.out) begin
         if (st_q.held && st_q.line != wr_line) begin
            st_d.out = 1'b1;
         end else begin
            st_d.held = 1'b1;
            st_d.line = wr_line;
            st_d.data = wr_data;
         end
      end
      // a line already on its way out is not queued a second time
      if (flush && st_q.held && !st_q.out) begin
         st_d.out = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = st_q.held;
   assign drain_valid = st_q.out;
   assign drain_line = st_q.line;
   assign drain_data = st_q.data;
endmodule // lfm_wc_buf
`default_nettype wire

// >>> lfm_miss_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module lfm_miss_ctl #(
   parameter int unsigned ENTRIES = lfm_pkg::MISS_ENTRIES,
   parameter int unsigned PRESET = lfm_pkg::STREAM_PRESET
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire lfm_pkg::lfm_req_s req,
   input wire logic req_hit,
   input wire logic pend_store_valid,
   input wire logic [lfm_pkg::ADDR_W-1:0] pend_store_addr,
   input wire lfm_pkg::lfm_fill_s fill,
   input wire lfm_pkg::lfm_evict_s evict,
   input wire logic mem_rd_ready,
   input wire logic mem_wr_ready,
   output logic req_ready,
   output logic [lfm_pkg::SET_W-1:0] req_set,
   output logic mem_rd_valid,
   output logic [lfm_pkg::LINE_W-1:0] mem_rd_line,
   output logic [lfm_pkg::MISS_IDX_W-1:0] mem_rd_idx,
   output logic fill_we,
   output logic [lfm_pkg::LINE_W-1:0] fill_line,
   output lfm_pkg::lfm_coh_e fill_coh,
   output logic fill_no_wb,
   output logic wb_valid,
   output logic [lfm_pkg::LINE_W-1:0] wb_line,
   output logic mem_wr_valid,
   output logic [lfm_pkg::LINE_W-1:0] mem_wr_line,
   output logic [lfm_pkg::DATA_W-1:0] mem_wr_data,
   output logic [15:0] id_l1_kb,
   output logic [15:0] id_l2_kb
);
   localparam int unsigned LW = lfm_pkg::LINE_W;
   localparam logic [LW-1:0] ONE_LINE = LW'(1);
   localparam logic [3:0] PRESET_N = 4'(PRESET);
   localparam int unsigned IW = lfm_pkg::MISS_IDX_W;
   localparam logic [IW-1:0] LAST_IDX = IW'(ENTRIES - 1);
   localparam logic [IW-1:0] ONE_IDX = IW'(1);

   typedef struct packed {
      lfm_pkg::lfm_miss_s [ENTRIES-1:0] ent;
      logic [ENTRIES-1:0] sent;
      logic [LW-1:0] last_miss;
      logic last_miss_v;
      logic stream_v;
      logic stream_nt;
      logic [LW-1:0] stream_next;
      logic [LW-1:0] stream_head;
      logic [3:0] stream_owed;
      logic rd_v;
      logic [LW-1:0] rd_line;
      logic [lfm_pkg::MISS_IDX_W-1:0] rd_idx;
      logic [lfm_pkg::MISS_IDX_W-1:0] alloc_ptr;
      logic [lfm_pkg::MISS_IDX_W-1:0] send_ptr;
      logic fw;
      logic [LW-1:0] fw_line;
      lfm_pkg::lfm_coh_e fw_coh;
      logic fw_nowb;
      logic wb_v;
      logic [LW-1:0] wb_l;
      logic ready;
      logic [lfm_pkg::SET_W-1:0] set;
      logic [15:0] l1kb;
      logic [15:0] l2kb;
   } lfm_st_s;
   lfm_st_s st_q, st_d;

   logic [LW-1:0] req_line;
   logic is_fa, is_read, is_wc, is_stream_st, store_block, match_any, full, free_v;
   logic demand_miss, wc_other, wc_flush, accept_ok;
   logic [lfm_pkg::MISS_IDX_W-1:0] free_idx, send_idx;
   logic send_v, wc_busy, wc_drain_v;
   logic [LW-1:0] wc_drain_line;
   logic [lfm_pkg::DATA_W-1:0] wc_drain_data;
   logic [ENTRIES-1:0] match_vec;

   assign req_line = req.addr[lfm_pkg::ADDR_W-1:lfm_pkg::LINE_OFF_W];
   assign is_fa = (req.op == lfm_pkg::LFM_OP_FA_PLAIN) || (req.op == lfm_pkg::LFM_OP_FA_HINT)
      || (req.op == lfm_pkg::LFM_OP_FA_WRITE) || (req.op == lfm_pkg::LFM_OP_FA_NT);
   assign is_wc = (req.range_mt == lfm_pkg::MT_WC) || (req.page_mt == lfm_pkg::MT_WC);
   assign is_stream_st = req.valid && (req.op == lfm_pkg::LFM_OP_STREAM_ST
      || (req.op == lfm_pkg::LFM_OP_STORE && is_wc));
   assign is_read = req.valid && (is_fa || req.op == lfm_pkg::LFM_OP_LOAD) && !req_hit;
   assign store_block = is_fa && pend_store_valid
      && pend_store_addr[lfm_pkg::ADDR_W-1:lfm_pkg::LINE_OFF_W] == req_line;
   assign demand_miss = is_read && !match_any;
   // a streaming store waits while the buffer holds another line or is draining
   assign wc_other = is_stream_st && wc_busy && (wc_drain_v || wc_drain_line != req_line);
   // fence and normal stores wait for the buffer to empty, and their wait drains it
   assign wc_flush = (req.valid && (req.op == lfm_pkg::LFM_OP_FENCE
      || (req.op == lfm_pkg::LFM_OP_STORE && !is_wc))) || wc_other;
   assign accept_ok = !(demand_miss && full) && !store_block && !wc_other
      && !(wc_flush && wc_busy);

   genvar gi;
   generate
      for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
         assign match_vec[gi] = st_q.ent[gi].valid && st_q.ent[gi].line == req_line;
      end
   endgenerate
   assign match_any = |match_vec;
   // allocation is strictly circular: an out-of-order fill is reused only when the pointer
   // comes round, traded for sending reads in issue order
   assign full = st_q.ent[st_q.alloc_ptr].valid;

   always_comb begin
      free_v = !full;
      free_idx = st_q.alloc_ptr;
      send_idx = st_q.send_ptr;
      send_v = st_q.ent[st_q.send_ptr].valid && !st_q.sent[st_q.send_ptr];
   end

   always_comb begin
      st_d = st_q;
      st_d.fw = 1'b0;
      st_d.wb_v = 1'b0;
      st_d.l1kb = 16'(lfm_pkg::L1_SIZE_KB);
      st_d.l2kb = 16'(lfm_pkg::L2_SIZE_KB);
      st_d.set = req.addr[lfm_pkg::LINE_OFF_W+lfm_pkg::SET_W-1:lfm_pkg::LINE_OFF_W];
      // ready speaks only for a request already seen, and drops for a cycle after a take
      st_d.ready = req.valid && !st_q.ready && accept_ok;
      if (st_q.rd_v && mem_rd_ready) begin
         st_d.rd_v = 1'b0;
      end
      if (send_v && (!st_q.rd_v || mem_rd_ready)) begin
         st_d.rd_v = 1'b1;
         st_d.rd_line = st_q.ent[send_idx].line;
         st_d.rd_idx = send_idx;
         st_d.sent[send_idx] = 1'b1;
         st_d.send_ptr = (st_q.send_ptr == LAST_IDX) ? '0 : st_q.send_ptr + ONE_IDX;
      end
      if (fill.valid && st_q.ent[fill.idx].valid) begin
         st_d.fw = 1'b1;
         st_d.fw_line = st_q.ent[fill.idx].line;
         st_d.fw_coh = st_q.ent[fill.idx].write_intent ? lfm_pkg::LFM_ST_MODIFIED
            : lfm_pkg::LFM_ST_EXCL;
         st_d.fw_nowb = st_q.ent[fill.idx].nt
            && (!fill.in_l2 || st_q.ent[fill.idx].hw_stream);
         st_d.ent[fill.idx].valid = 1'b0;
         st_d.sent[fill.idx] = 1'b0;
      end
      if (evict.valid && !evict.no_wb) begin
         st_d.wb_v = 1'b1;
         st_d.wb_l = evict.line;
      end
      if (is_read && st_q.ready && !match_any && free_v && !store_block) begin
         st_d.ent[free_idx].valid = 1'b1;
         st_d.ent[free_idx].line = req_line;
         st_d.ent[free_idx].nt = (req.op == lfm_pkg::LFM_OP_FA_NT);
         st_d.ent[free_idx].write_intent = (req.op == lfm_pkg::LFM_OP_FA_WRITE);
         st_d.ent[free_idx].hw_stream = 1'b0;
         st_d.sent[free_idx] = 1'b0;
         st_d.alloc_ptr = (st_q.alloc_ptr == LAST_IDX) ? '0 : st_q.alloc_ptr + ONE_IDX;
         st_d.last_miss = req_line;
         st_d.last_miss_v = 1'b1;
         if (st_q.last_miss_v && req_line == st_q.last_miss + ONE_LINE) begin
            st_d.stream_v = 1'b1;
            st_d.stream_nt = (req.op == lfm_pkg::LFM_OP_FA_NT);
            st_d.stream_next = req_line + ONE_LINE;
            st_d.stream_head = req_line + ONE_LINE;
            st_d.stream_owed = PRESET_N;
         end
      end else if (req.valid && st_q.ready && st_q.stream_v && !is_stream_st
            && req_line == st_q.stream_head) begin
         st_d.stream_head = st_q.stream_head + ONE_LINE;
         st_d.stream_owed = st_q.stream_owed + 4'h1;
      end
      if (st_q.stream_v && st_q.stream_owed != 4'h0 && free_v
            && !demand_miss) begin
         st_d.ent[free_idx].valid = 1'b1;
         st_d.ent[free_idx].line = st_q.stream_next;
         st_d.ent[free_idx].nt = st_q.stream_nt;
         st_d.ent[free_idx].write_intent = 1'b0;
         st_d.ent[free_idx].hw_stream = 1'b1;
         st_d.sent[free_idx] = 1'b0;
         st_d.alloc_ptr = (st_q.alloc_ptr == LAST_IDX) ? '0 : st_q.alloc_ptr + ONE_IDX;
         st_d.stream_next = st_q.stream_next + ONE_LINE;
         st_d.stream_owed = st_d.stream_owed - 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // streaming data never allocates a miss entry, so no line read is made
   lfm_wc_buf u_wc (
      .clk_sys(clk_sys),
      .srst(srst),
      .wr_valid(is_stream_st && st_q.ready),
      .wr_line(req_line),
      .wr_data(req.data),
      .flush(wc_flush),
      .drain_ready(mem_wr_ready),
      .busy(wc_busy),
      .drain_valid(wc_drain_v),
      .drain_line(wc_drain_line),
      .drain_data(wc_drain_data)
   );

   assign req_ready = st_q.ready;
   assign req_set = st_q.set;
   assign mem_rd_valid = st_q.rd_v;
   assign mem_rd_line = st_q.rd_line;
   assign mem_rd_idx = st_q.rd_idx;
   assign fill_we = st_q.fw;
   assign fill_line = st_q.fw_line;
   assign fill_coh = st_q.fw_coh;
   assign fill_no_wb = st_q.fw_nowb;
   assign wb_valid = st_q.wb_v;
   assign wb_line = st_q.wb_l;
   assign mem_wr_valid = wc_drain_v;
   assign mem_wr_line = wc_drain_line;
   assign mem_wr_data = wc_drain_data;
   assign id_l1_kb = st_q.l1kb;
   assign id_l2_kb = st_q.l2kb;
endmodule // lfm_miss_ctl
`default_nettype wire

// >>> lfm_miss_ctl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module lfm_miss_chk #(
   parameter int unsigned ENTRIES = 8,
   parameter int unsigned PRESET = 3
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire lfm_pkg::lfm_req_s req,
   input wire logic req_ready,
   input wire logic [lfm_pkg::SET_W-1:0] req_set,
   input wire logic mem_rd_valid,
   input wire logic mem_rd_ready,
   input wire logic [lfm_pkg::LINE_W-1:0] mem_rd_line,
   input wire logic [lfm_pkg::MISS_IDX_W-1:0] mem_rd_idx,
   input wire lfm_pkg::lfm_fill_s fill,
   input wire lfm_pkg::lfm_evict_s evict,
   input wire logic fill_we,
   input wire lfm_pkg::lfm_coh_e fill_coh,
   input wire logic wb_valid,
   input wire logic [lfm_pkg::LINE_W-1:0] wb_line,
   input wire logic [15:0] id_l1_kb,
   input wire logic [15:0] id_l2_kb
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // misses handed to the far side and not yet filled
   logic [4:0] open_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         open_q <= 5'h00;
      end else begin
         open_q <= open_q + 5'(mem_rd_valid && mem_rd_ready) - 5'(fill.valid);
      end
   end
   chk_set_index: assert property (req.valid && req_ready |=> req_set == $past(req.addr[14:6]))
      else $error("set index mismatch");
   chk_rd_hold: assert property (mem_rd_valid && !mem_rd_ready |=> mem_rd_valid &&
      $stable(mem_rd_line) && $stable(mem_rd_idx)) else $error("read request dropped");
   chk_fill_next: assert property (fill.valid |=> fill_we)
      else $error("fill not stored");
   chk_fill_state: assert property (fill_we |-> fill_coh == lfm_pkg::LFM_ST_EXCL ||
      fill_coh == lfm_pkg::LFM_ST_MODIFIED) else $error("bad fill state");
   chk_wb_block: assert property (evict.valid && evict.no_wb |=> !wb_valid)
      else $error("marked line written back");
   chk_wb_pass: assert property (evict.valid && !evict.no_wb |=> wb_valid &&
      wb_line == $past(evict.line)) else $error("victim not written back");
   chk_miss_limit: assert property (open_q <= ENTRIES)
      else $error("too many open misses");
   chk_ident_size: assert property (!srst [*3] |-> id_l1_kb == 16'(lfm_pkg::L1_SIZE_KB) &&
      id_l2_kb == 16'(lfm_pkg::L2_SIZE_KB)) else $error("size report wrong");
endmodule // lfm_miss_chk
bind lfm_miss_ctl lfm_miss_chk #(.ENTRIES(ENTRIES), .PRESET(PRESET)) i_chk (.clk_sys, .srst,
   .req, .req_ready, .req_set, .mem_rd_valid, .mem_rd_ready, .mem_rd_line, .mem_rd_idx, .fill,
   .evict, .fill_we, .fill_coh, .wb_valid, .wb_line, .id_l1_kb, .id_l2_kb);
`default_nettype wire

// >>> lfm_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// second level: takes a read every other cycle, fills in order; hold stalls fills
module lfm_mem_model (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic hold,
   input wire logic mem_rd_valid,
   input wire logic [lfm_pkg::LINE_W-1:0] mem_rd_line,
   input wire logic [lfm_pkg::MISS_IDX_W-1:0] mem_rd_idx,
   output logic mem_rd_ready,
   output logic mem_wr_ready,
   output lfm_pkg::lfm_fill_s fill
);
   logic [lfm_pkg::MISS_IDX_W:0] q[$];
   logic ph;
   always @(posedge clk_sys) begin
      ph <= srst ? 1'b0 : ~ph;
      fill.valid <= 1'b0;
      fill.idx <= ~fill.idx;
      fill.in_l2 <= ~fill.in_l2;
      if (srst) begin
         q.delete();
         fill <= '0;
      end else begin
         // odd lines are taken as present in the second level
         if (mem_rd_valid && mem_rd_ready) q.push_back({mem_rd_line[0], mem_rd_idx});
         if (ph && !hold && q.size() > 0) begin
            {fill.in_l2, fill.idx} <= q.pop_front();
            fill.valid <= 1'b1;
         end
      end
   end
   assign mem_rd_ready = ph;
   assign mem_wr_ready = 1'b1;
endmodule // lfm_mem_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [3:0] op;
      logic [11:0] line;
      logic [3:0] hint;
      logic [3:0] wc;
      logic hit;
      logic rd;
      logic nw;
      logic nowb;
      logic [3:0] coh;
   } lfm_row_s;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic hold = 1'b0;
   lfm_pkg::lfm_req_s req = '0;
   logic req_hit = 1'b0;
   logic pend_store_valid = 1'b0;
   logic [lfm_pkg::ADDR_W-1:0] pend_store_addr = '0;
   lfm_pkg::lfm_evict_s evict = '0;
   lfm_pkg::lfm_fill_s fill;
   lfm_pkg::lfm_coh_e fill_coh;
   logic mem_rd_ready, mem_wr_ready, req_ready, mem_rd_valid, fill_we, fill_no_wb, wb_valid;
   logic mem_wr_valid;
   logic [lfm_pkg::DATA_W-1:0] mem_wr_data;
   logic [15:0] wd;
   logic [lfm_pkg::SET_W-1:0] req_set;
   logic [lfm_pkg::LINE_W-1:0] mem_rd_line, fill_line, wb_line, mem_wr_line, wl;
   logic [lfm_pkg::MISS_IDX_W-1:0] mem_rd_idx;
   logic [15:0] id_l1_kb, id_l2_kb;
   int err_total = 0;
   int cmp_count = 0;
   int wr_n = 0;
   int n0, f0, wexp;
   lfm_row_s r;
   logic [lfm_pkg::LINE_W-1:0] rd_q[$];
   logic [lfm_pkg::LINE_W+2:0] fq[$];
   // op line hint wc {hit rd nw nowb} coh
   logic [31:0] rows[15] = '{32'h0100_0042, 32'h0100_0080, 32'h2200_0042, 32'h3202_0042,
      32'h3204_1042, 32'h3206_2042, 32'h4208_0043, 32'h520B_0042, 32'h5210_0052, 32'h6300_0000,
      32'h7000_0020, 32'h1302_0100, 32'h7000_0020, 32'h1304_0200, 32'h7000_0020};
   always #5 clk_sys = ~clk_sys;
   lfm_miss_ctl i_dut (.clk_sys, .srst, .req, .req_hit, .pend_store_valid, .pend_store_addr,
      .fill, .evict, .mem_rd_ready, .mem_wr_ready, .req_ready, .req_set, .mem_rd_valid,
      .mem_rd_line, .mem_rd_idx, .fill_we, .fill_line, .fill_coh, .fill_no_wb, .wb_valid,
      .wb_line, .mem_wr_valid, .mem_wr_line, .mem_wr_data, .id_l1_kb, .id_l2_kb);
   lfm_mem_model i_mem (.clk_sys, .srst, .hold, .mem_rd_valid, .mem_rd_line, .mem_rd_idx,
      .mem_rd_ready, .mem_wr_ready, .fill);
   always @(posedge clk_sys) begin
      if (mem_rd_valid && mem_rd_ready) rd_q.push_back(mem_rd_line);
      if (mem_wr_valid && mem_wr_ready) begin
         wr_n++;
         wl = mem_wr_line;
         wd = mem_wr_data[15:0];
      end
      if (fill_we) fq.push_back({fill_no_wb, fill_coh, fill_line});
   end
   task automatic end_sim();
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input lfm_row_s x);
      @(negedge clk_sys);
      req = '{valid: 1'b1, op: lfm_pkg::lfm_op_e'(x.op[2:0]), addr: 48'(x.line) << 6,
         hint: x.hint[1:0], range_mt: x.wc == 4'h1 ? lfm_pkg::MT_WC : lfm_pkg::MT_WB,
         page_mt: x.wc == 4'h2 ? lfm_pkg::MT_WC : lfm_pkg::MT_WB, data: {32{x.line, 4'h0}}};
      req_hit = x.hit;
   endtask
   task automatic fail_out();
      err_total++;
      end_sim();
   endtask
   task automatic take(input int lim);
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > lim) fail_out();
      end
      @(negedge clk_sys);
      req.valid = 1'b0;
   endtask
   task automatic upto(input int w, input int target);
      int n;
      n = 0;
      while ((w == 0 ? rd_q.size() : w == 1 ? fq.size() : wr_n) < target) begin
         @(negedge clk_sys);
         n++;
         if (n > 400) fail_out();
      end
   endtask
   initial begin
      wexp = 0;
      repeat (20) @(negedge clk_sys);
      chk(req_ready, 0);
      chk(mem_rd_valid, 0);
      srst = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(id_l1_kb, lfm_pkg::L1_SIZE_KB);
      chk(id_l2_kb, lfm_pkg::L2_SIZE_KB);
      foreach (rows[i]) begin
         r = lfm_row_s'(rows[i]);
         n0 = rd_q.size();
         f0 = fq.size();
         wexp += r.nw;
         put(r);
         take(100);
         chk(req_set, r.line[8:0]);
         if (r.rd) begin
            upto(1, f0 + 1);
            chk(fq[f0], {r.nowb, r.coh[1:0], 42'(r.line)});
         end
         upto(2, wexp);
         repeat (6) @(negedge clk_sys);
         chk(rd_q.size(), n0 + r.rd);
         if (r.nw) chk(wl, rows[i-1][27:16]);
         if (r.nw) chk(wd, {rows[i-1][27:16], 4'h0});
      end
      n0 = rd_q.size();
      f0 = fq.size();
      put(lfm_row_s'(32'h5400_0000));
      take(100);
      put(lfm_row_s'(32'h5401_0000));
      take(100);
      upto(1, f0 + 5);
      for (int k = 0; k < 5; k++) begin
         chk(rd_q[n0+k], 'h400 + k);
         chk(fq[f0+k][lfm_pkg::LINE_W+2], k != 1);
      end
      hold = 1'b1;
      n0 = rd_q.size();
      f0 = fq.size();
      for (int k = 0; k < 8; k++) begin
         put(lfm_row_s'({4'h0, 12'h500 + 12'(2 * k), 16'h0000}));
         take(100);
      end
      upto(0, n0 + 8);
      for (int k = 0; k < 8; k++) chk(rd_q[n0+k], 'h500 + 2 * k);
      put(lfm_row_s'(32'h0506_0000));
      take(100);
      put(lfm_row_s'(32'h0520_0000));
      repeat (20) begin
         @(negedge clk_sys);
         chk(req_ready, 0);
      end
      hold = 1'b0;
      take(200);
      upto(1, f0 + 9);
      chk(rd_q.size(), n0 + 9);
      pend_store_valid = 1'b1;
      pend_store_addr = 48'h600 << 6;
      put(lfm_row_s'(32'h2600_0000));
      repeat (10) begin
         @(negedge clk_sys);
         chk(req_ready, 0);
      end
      pend_store_valid = 1'b0;
      take(100);
      for (int k = 0; k < 2; k++) begin
         evict = '{1'b1, 42'h700 + 42'(k), lfm_pkg::LFM_ST_MODIFIED, k == 0};
         @(negedge clk_sys);
         evict.valid = 1'b0;
         chk(wb_valid, k);
         if (k == 1) chk(wb_line, 'h701);
      end
      end_sim();
   end
endmodule // tb
`default_nettype wire
